/* core/sfa_addr_mode_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Works with clock idling high or low
// - Offer 32-bit addressing for full array
// - Enter-wide command sets wide-address flag
// - Wide flag means 32 address bits; exit restores
// - Wide mode ignores segment bit zero
// - Dedicated 4-byte opcodes always take 32 bits
// - Eight-bit volatile segment register supplies A31-A24
// - Upper segment bits read zero; bit0 resets zero
// - 3-byte accesses act within selected segment; EAh uses the upper segment outside wide mode
// - Continuous read crosses segments, register unchanged
// - New 3-byte address stays in segment
// - Chip erase covers whole array always
// - Opcode 35h enters four-line command protocol
// - Opcode F5h returns to single-line commands
// - Mode commands need select rise on byte boundary
// - Sample on clock rise, launch on fall
module sfa_addr_mode_ctrl
  import sfa_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // Serial link pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic [3:0]        io_in,
  output logic [3:0]             io_out,
  output logic [3:0]             io_oe,
  // Array read side
  output logic [31:0]            array_addr,
  input  wire logic [7:0]        array_byte,
  // Decoded command stream
  output logic                   cmd_valid,
  input  wire logic              cmd_ready,
  output sfa_cmd_type            cmd_data,
  // Mode indications
  output logic                   wide_address_flag,
  output logic                   quad_mode
);

  function automatic logic is_4b(input logic [7:0] op);
    return op == OP_READ4 || op == OP_FAST4 || op == OP_READ4_2IO || op == OP_READ4_2O ||
           op == OP_READ4_4IO || op == OP_READ4_4O;
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    return is_4b(op) || op == OP_READ || op == OP_FAST || op == OP_READ_2IO ||
           op == OP_READ_2O || op == OP_READ_4IO || op == OP_READ_4IO_TOP || op == OP_READ_4O;
  endfunction

  function automatic logic is_prog(input logic [7:0] op);
    return op == OP_PROG || op == OP_PROG_4IO;
  endfunction

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_ERASE_SECT || op == OP_ERASE_32K || op == OP_ERASE_64K;
  endfunction

  // Lines used per clock; out_ph selects the data-out phase
  function automatic logic [2:0] lanes(input logic [7:0] op, input logic quad, input logic out_ph);
    if (quad || op == OP_READ_4IO || op == OP_READ4_4IO || op == OP_READ_4IO_TOP ||
        (op == OP_PROG_4IO && !out_ph)) begin
      return 3'h4;
    end else if (out_ph && (op == OP_READ_4O || op == OP_READ4_4O)) begin
      return 3'h4;
    end else if (op == OP_READ_2IO || op == OP_READ4_2IO ||
                 (out_ph && (op == OP_READ_2O || op == OP_READ4_2O))) begin
      return 3'h2;
    end else begin
      return 3'h1;
    end
  endfunction

  function automatic logic [31:0] shift_in(input logic [31:0] sr, input logic [3:0] io,
                                           input logic [2:0] n);
    case (n)
      3'h4:    return {sr[27:0], io};
      3'h2:    return {sr[29:0], io[1:0]};
      default: return {sr[30:0], io[0]};
    endcase
  endfunction

  // Pin synchronisers; stage 1 feeds stage 2 only
  logic       cs_s1, cs_s2, cs_s3;
  logic       ck_s1, ck_s2, ck_s3;
  logic [3:0] io_s1, io_s2;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ck_s1 <= sclk;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      io_s1 <= io_in;
      io_s2 <= io_s1;
    end
  end

  logic sck_rise, sck_fall, sel, cs_rise;
  assign sck_rise = ck_s2 && !ck_s3 && !cs_s2;
  assign sck_fall = !ck_s2 && ck_s3 && !cs_s2;
  assign sel      = !cs_s2;
  assign cs_rise  = cs_s2 && !cs_s3;

  sfa_state_type state_r;
  logic [31:0]   sr_r;
  logic [5:0]    ph_cnt_r;
  logic [2:0]    bit_mod_r;
  logic [7:0]    op_r;
  logic [31:0]   cmd_addr_r;
  logic          seg_r;
  logic          pend_r;
  sfa_cmd_type   pend_data_r;
  logic          ovf_pulse_r;
  logic          rej_pulse_r;
  logic          buf_ready;

  logic [2:0]    in_lanes;
  logic [31:0]   sr_next;
  logic [5:0]    ph_next;
  logic [5:0]    addr_need;
  logic [7:0]    dummy_need;
  logic [31:0]   eff_addr;
  sfa_cmd_type   new_cmd;

  always_comb begin
    in_lanes   = (state_r == LS_OPCODE) ? (quad_mode ? 3'h4 : 3'h1) : lanes(op_r, quad_mode, 1'b0);
    sr_next    = shift_in(sr_r, io_s2, in_lanes);
    ph_next    = ph_cnt_r + {3'h0, in_lanes};
    // wide flag or 4-byte opcode widens
    addr_need  = (wide_address_flag || is_4b(op_r)) ? 6'(ADDR4_BITS) : 6'(ADDR3_BITS);
    dummy_need = (op_r == OP_READ || op_r == OP_READ4) ? 8'h00 :
                 (lanes(op_r, 1'b0, 1'b0) == 3'h4) ? 8'(DUMMY_QIO) : 8'(DUMMY_STD);
    // in wide mode the segment bit is unused
    if (wide_address_flag || is_4b(op_r)) begin
      eff_addr = {7'h00, sr_next[ARRAY_BITS-1:0]};
    // segment bit sits above 24 bits
    end else if (op_r == OP_READ_4IO_TOP) begin
      eff_addr = {7'h00, 1'b1, sr_next[ADDR3_BITS-1:0]};
    end else begin
      eff_addr = {7'h00, seg_r, sr_next[ADDR3_BITS-1:0]};
    end
    new_cmd.opcode = op_r;
    new_cmd.addr   = eff_addr;
    new_cmd.kind   = is_read(op_r) ? CMD_READ : is_prog(op_r) ? CMD_PROGRAM : CMD_ERASE;
  end

  // Command framing state machine; runs on sampled clock rises
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r           <= LS_OPCODE;
      sr_r              <= 32'h0;
      ph_cnt_r          <= 6'h0;
      bit_mod_r         <= 3'h0;
      op_r              <= 8'h00;
      cmd_addr_r        <= 32'h0;
      wide_address_flag <= 1'b0;
      quad_mode         <= 1'b0;
      rej_pulse_r       <= 1'b0;
    end else begin
      rej_pulse_r <= 1'b0;
      if (cs_rise) begin
        if (state_r == LS_IGNORE && bit_mod_r == 3'h0) begin
          case (op_r)
            OP_ENTER_WIDE: wide_address_flag <= 1'b1;
            OP_EXIT_WIDE:  wide_address_flag <= 1'b0;
            OP_QUAD_ENTER: quad_mode <= 1'b1;
            OP_QUAD_EXIT:  quad_mode <= 1'b0;
            default:       ;
          endcase
        end else if (state_r == LS_IGNORE) begin
          rej_pulse_r <= 1'b1;
        end
      end
      if (!sel) begin
        state_r   <= LS_OPCODE;
        ph_cnt_r  <= 6'h0;
        bit_mod_r <= 3'h0;
      end else if (sck_rise) begin
        sr_r      <= sr_next;
        bit_mod_r <= bit_mod_r + in_lanes;
        case (state_r)
          LS_OPCODE: begin
            ph_cnt_r <= ph_next;
            if (ph_next == 6'(BYTE_BITS)) begin
              op_r     <= sr_next[7:0];
              ph_cnt_r <= 6'h0;
              if (is_read(sr_next[7:0]) || is_prog(sr_next[7:0]) || is_erase(sr_next[7:0])) begin
                state_r <= LS_ADDR;
              end else begin
                state_r <= LS_IGNORE;
              end
            end
          end
          LS_ADDR: begin
            ph_cnt_r <= ph_next;
            if (ph_next == addr_need) begin
              cmd_addr_r <= eff_addr;
              ph_cnt_r   <= 6'h0;
              if (!is_read(op_r)) begin
                state_r <= LS_IGNORE;
              end else if (dummy_need == 8'h00) begin
                state_r <= LS_DATA;
              end else begin
                state_r <= LS_DUMMY;
              end
            end
          end
          LS_DUMMY: begin
            ph_cnt_r <= ph_cnt_r + 6'h1;
            if (8'(ph_cnt_r) + 8'h01 == dummy_need) begin
              state_r <= LS_DATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Command hand-off; a pending word waits for buffer room
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_r      <= 1'b0;
      pend_data_r <= '0;
      ovf_pulse_r <= 1'b0;
    end else begin
      ovf_pulse_r <= 1'b0;
      if (pend_r && buf_ready) begin
        pend_r <= 1'b0;
      end
      if (sck_rise && state_r == LS_ADDR && ph_next == addr_need) begin
        if (pend_r && !buf_ready) begin
          ovf_pulse_r <= 1'b1;
        end else begin
          pend_r      <= 1'b1;
          pend_data_r <= new_cmd;
        end
      end else if (cs_rise && state_r == LS_IGNORE && bit_mod_r == 3'h0 &&
                   (op_r == OP_CHIP_ERASE_A || op_r == OP_CHIP_ERASE_B)) begin
        if (pend_r && !buf_ready) begin
          ovf_pulse_r <= 1'b1;
        end else begin
          pend_r             <= 1'b1;
          pend_data_r.kind   <= CMD_CHIP_ERASE;
          pend_data_r.opcode <= op_r;
          pend_data_r.addr   <= 32'h0;
        end
      end
    end
  end

  sfa_pair_buf #(
    .W ($bits(sfa_cmd_type))
  ) u_buf (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (pend_r),
    .in_ready  (buf_ready),
    .in_data   (pend_data_r),
    .out_valid (cmd_valid),
    .out_ready (cmd_ready),
    .out_data  (cmd_data)
  );

  // Data-out shifter
  logic [7:0]            out_sh_r;
  logic [2:0]            out_cnt_r;
  logic [ARRAY_BITS-1:0] offs_r;
  logic [2:0]            out_lanes;
  logic [7:0]            out_src;

  assign out_lanes = lanes(op_r, quad_mode, 1'b1);
  assign out_src   = (out_cnt_r == 3'h0) ? array_byte : out_sh_r;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_sh_r   <= 8'h00;
      out_cnt_r  <= 3'h0;
      offs_r     <= '0;
      io_out     <= 4'h0;
      io_oe      <= 4'h0;
      array_addr <= 32'h0;
    end else begin
      // offset wraps across segments, seg_r untouched
      array_addr <= {7'h00, cmd_addr_r[ARRAY_BITS-1:0] + offs_r};
      if (!sel || state_r != LS_DATA) begin
        out_cnt_r <= 3'h0;
        offs_r    <= '0;
        io_oe     <= 4'h0;
      end else if (sck_fall) begin
        out_cnt_r <= out_cnt_r + out_lanes;
        out_sh_r  <= out_src << out_lanes;
        if (out_cnt_r + out_lanes == 3'h0) begin
          offs_r <= offs_r + 1'b1;
        end
        case (out_lanes)
          3'h4: begin
            io_out <= out_src[7:4];
            io_oe  <= OE_X4;
          end
          3'h2: begin
            io_out <= {2'h0, out_src[7:6]};
            io_oe  <= OE_X2;
          end
          default: begin
            io_out <= {2'h0, out_src[7], 1'b0};
            io_oe  <= OE_X1;
          end
        endcase
      end
    end
  end

  // Registers: segment, sticky status
  logic ovf_r, rej_r;
  logic [31:0] status_word;
  assign status_word = {16'h0, op_r, 4'h0, rej_r, ovf_r, quad_mode, wide_address_flag};

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      seg_r     <= EXT_SEG_RST[0];
      ovf_r     <= 1'b0;
      rej_r     <= 1'b0;
      reg_rdata <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == REG_EXT_SEG) begin
        seg_r <= reg_wdata[0];
      end
      // Set wins over a write-one clear in the same cycle
      ovf_r <= ovf_pulse_r || (ovf_r && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_OVF_BIT]));
      rej_r <= rej_pulse_r || (rej_r && !(reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_REJ_BIT]));
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          REG_EXT_SEG: reg_rdata <= {24'h0, 7'h00, seg_r};
          REG_STATUS:  reg_rdata <= status_word;
          default:     reg_rdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

/* core/sfa_pkg.sv */
package sfa_pkg;

  // Register port map
  localparam int          REG_AW          = 4;
  localparam logic [3:0]  REG_EXT_SEG     = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [7:0]  EXT_SEG_RST     = 8'h00;
  localparam int          ST_WIDE_BIT     = 0;
  localparam int          ST_QUAD_BIT     = 1;
  localparam int          ST_OVF_BIT      = 2;
  localparam int          ST_REJ_BIT      = 3;
  localparam int          ST_OP_LSB       = 8;

  // Address forming
  localparam int          BYTE_BITS       = 8;
  localparam int          ADDR3_BITS      = 24;
  localparam int          ADDR4_BITS      = 32;
  localparam int          ARRAY_BITS      = 25;
  localparam int          DUMMY_STD       = 8;
  localparam int          DUMMY_QIO       = 6;

  // Lane masks for the data-out phase
  localparam logic [3:0]  OE_X1           = 4'h2;
  localparam logic [3:0]  OE_X2           = 4'h3;
  localparam logic [3:0]  OE_X4           = 4'hf;

  // Opcodes
  localparam logic [7:0]  OP_ENTER_WIDE   = 8'hb7;
  localparam logic [7:0]  OP_EXIT_WIDE    = 8'he9;
  localparam logic [7:0]  OP_QUAD_ENTER   = 8'h35;
  localparam logic [7:0]  OP_QUAD_EXIT    = 8'hf5;
  localparam logic [7:0]  OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0]  OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_FAST         = 8'h0b;
  localparam logic [7:0]  OP_READ_2IO     = 8'hbb;
  localparam logic [7:0]  OP_READ_2O      = 8'h3b;
  localparam logic [7:0]  OP_READ_4IO     = 8'heb;
  localparam logic [7:0]  OP_READ_4IO_TOP = 8'hea;
  localparam logic [7:0]  OP_READ_4O      = 8'h6b;
  localparam logic [7:0]  OP_READ4        = 8'h13;
  localparam logic [7:0]  OP_FAST4        = 8'h0c;
  localparam logic [7:0]  OP_READ4_2IO    = 8'hbc;
  localparam logic [7:0]  OP_READ4_2O     = 8'h3c;
  localparam logic [7:0]  OP_READ4_4IO    = 8'hec;
  localparam logic [7:0]  OP_READ4_4O     = 8'h6c;
  localparam logic [7:0]  OP_PROG         = 8'h02;
  localparam logic [7:0]  OP_PROG_4IO     = 8'h38;
  localparam logic [7:0]  OP_ERASE_SECT   = 8'h20;
  localparam logic [7:0]  OP_ERASE_32K    = 8'h52;
  localparam logic [7:0]  OP_ERASE_64K    = 8'hd8;

  typedef enum logic [1:0] {
    CMD_READ,
    CMD_PROGRAM,
    CMD_ERASE,
    CMD_CHIP_ERASE
  } sfa_kind_type;

  typedef struct packed {
    sfa_kind_type kind;
    logic [7:0]   opcode;
    logic [31:0]  addr;
  } sfa_cmd_type;

  typedef enum logic [2:0] {
    LS_OPCODE,
    LS_ADDR,
    LS_DUMMY,
    LS_DATA,
    LS_IGNORE
  } sfa_state_type;

endpackage

/* core/sfa_pair_buf.sv */
`timescale 1ns/1ps
module sfa_pair_buf #(
  parameter int W = 42
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] tail_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign in_ready = (cnt_r != 2'h2);
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_r     <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      cnt_r     <= cnt_r + {1'b0, push} - {1'b0, pop};
      out_valid <= (cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

  // Head is always the oldest word, so the output stays a plain flop
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_data <= '0;
      tail_r   <= '0;
    end else begin
      if (pop) begin
        out_data <= (cnt_r == 2'h2) ? tail_r : in_data;
      end else if (push && cnt_r == 2'h0) begin
        out_data <= in_data;
      end
      if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop))) begin
        tail_r <= in_data;
      end
    end
  end
endmodule

/* dv/sfa_addr_mode_ctrl_assertions.sv */
`timescale 1ns/1ps
module sfa_addr_mode_ctrl_assertions
  import sfa_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset_n,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // Link side
  input wire logic              cs_n,
  input wire logic [3:0]        io_oe,
  input wire logic [31:0]       array_addr,
  // Command stream and modes
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire sfa_cmd_type       cmd_data,
  input wire logic              wide_address_flag,
  input wire logic              quad_mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_seg_rd;
    reg_rd && reg_addr == REG_EXT_SEG;
  endsequence
  sequence s_st_rd;
    reg_rd && reg_addr == REG_STATUS;
  endsequence
  // Seven idle cycles leave room for the pin synchroniser
  sequence s_cs_settled;
    $rose(cs_n) ##1 cs_n [*7];
  endsequence
  a_seg_upper_zero: assert property (s_seg_rd |=> reg_rdata[31:1] == 31'h0)
    else $error("Segment read shows upper bits");
  a_status_wide: assert property (s_st_rd |=> reg_rdata[ST_WIDE_BIT] == $past(wide_address_flag))
    else $error("Status wide bit differs");
  a_status_quad: assert property (s_st_rd |=> reg_rdata[ST_QUAD_BIT] == $past(quad_mode))
    else $error("Status quad bit differs");
  a_wide_at_rise: assert property ($changed(wide_address_flag) |-> cs_n && $past(cs_n))
    else $error("Wide flag moved inside a frame");
  a_quad_at_rise: assert property ($changed(quad_mode) |-> cs_n && $past(cs_n))
    else $error("Quad mode moved inside a frame");
  a_modes_settled: assert property (s_cs_settled |-> $stable(wide_address_flag) && $stable(quad_mode))
    else $error("Mode flags moving long after deselect");
  a_oe_released: assert property (s_cs_settled |-> io_oe == 4'h0)
    else $error("Lanes driven while deselected");
  a_array_in_range: assert property (array_addr[31:25] == 7'h0)
    else $error("Array address above 25 bits");
  a_chip_erase_all: assert property (cmd_valid && cmd_data.kind == CMD_CHIP_ERASE |-> cmd_data.addr == 32'h0)
    else $error("Chip erase word has an address");
  a_cmd_held: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("Command word changed before acceptance");
  // Outside wide mode the top-half quad read lands above the 24 received bits
  a_top_read_seg: assert property (cmd_valid && cmd_data.opcode == OP_READ_4IO_TOP && !wide_address_flag |-> cmd_data.addr[31:24] == 8'h01)
    else $error("Top-half read word not in upper segment");
endmodule

bind sfa_addr_mode_ctrl sfa_addr_mode_ctrl_assertions sfa_addr_mode_ctrl_assertions_inst (
  .core_clk, .reset_n, .reg_addr, .reg_rd, .reg_rdata, .cs_n, .io_oe, .array_addr,
  .cmd_valid, .cmd_ready, .cmd_data, .wide_address_flag, .quad_mode
);

/* dv/sfa_host_model.sv */
`timescale 1ns/1ps
module sfa_host_model (
  // Clock
  input  wire logic       core_clk,
  // Serial link
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  localparam int MIN_DESEL = 8;
  logic       cpol;
  logic [3:0] hen;
  logic [3:0] hval;
  logic [3:0] junk;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    cpol = 1'b0;
    hen  = 4'h0;
    hval = 4'h0;
    junk = 4'h5;
  end
  // Undriven lines toggle so stale data never passes for valid
  always @(posedge core_clk) junk <= ~junk;
  assign io_in = (io_oe & io_out) | (~io_oe & hen & hval) | (~io_oe & ~hen & junk);
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  // drive in low phase, rise samples
  task automatic shift(input logic [31:0] v, input int n, input int ln);
    for (int i = n - ln; i >= 0; i -= ln) begin
      sclk <= 1'b0;
      hen  <= 4'((1 << ln) - 1);
      hval <= 4'((v >> i) & ((1 << ln) - 1));
      half();
      sclk <= 1'b1;
      half();
    end
  endtask
  task automatic rx(output logic [7:0] b, input int ln);
    b = 8'h0;
    for (int i = 0; i < 8; i += ln) begin
      sclk <= 1'b0;
      hen  <= 4'h0;
      half();
      sclk <= 1'b1;
      half();
      b = (b << ln) | 8'(ln == 1 ? {3'h0, io_in[1]} : io_in & 4'((1 << ln) - 1));
    end
  endtask
  task automatic start(input logic pol);
    sclk <= pol;
    cpol <= pol;
    half();
    cs_n <= 1'b0;
    half();
  endtask
  task automatic stop();
    sclk <= cpol;
    hen  <= 4'h0;
    half();
    cs_n <= 1'b1;
    repeat (MIN_DESEL) @(posedge core_clk);
  endtask
endmodule

/* dv/sfa_addr_mode_ctrl_tb.sv */
`timescale 1ns/1ps
module sfa_addr_mode_ctrl_tb
  import sfa_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              reset_n = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic              cs_n;
  logic              sclk;
  logic [3:0]        io_in;
  logic [3:0]        io_out;
  logic [3:0]        io_oe;
  logic [31:0]       array_addr;
  logic [7:0]        array_byte;
  logic              cmd_valid;
  logic              cmd_ready = 1'b0;
  sfa_cmd_type       cmd_data;
  logic              wide_address_flag;
  logic              quad_mode;
  logic              stall = 1'b0;
  logic              seg = 1'b0;
  logic              wide = 1'b0;
  logic              quad = 1'b0;
  integer            seed = 18;
  int                error_cnt = 0;
  int                num_checks = 0;
  sfa_cmd_type       expq[$];
  sfa_cmd_type       gotq[$];
  logic [7:0]        ops [18] = '{8'h03, 8'h0b, 8'hbb, 8'h3b, 8'heb, 8'h6b, 8'hea, 8'h13, 8'h0c, 8'hbc,
                                  8'h3c, 8'hec, 8'h6c, 8'h02, 8'h38, 8'h20, 8'h52, 8'hd8};
  sfa_addr_mode_ctrl sfa_addr_mode_ctrl_inst (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cs_n, .sclk, .io_in,
    .io_out, .io_oe, .array_addr, .array_byte, .cmd_valid, .cmd_ready, .cmd_data, .wide_address_flag, .quad_mode
  );
  sfa_host_model sfa_host_model_inst (.core_clk, .cs_n, .sclk, .io_in, .io_out, .io_oe);
  always #10 core_clk = ~core_clk;
  // Array content depends on bit 24 so the two segments differ
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[24:17];
  endfunction
  assign array_byte = mb(array_addr);
  always @(posedge core_clk) begin
    if (cmd_valid && cmd_ready)
      gotq.push_back(cmd_data);
    cmd_ready <= !stall && ($random(seed) % 3 != 0);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [REG_AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic st(input logic ovf, input logic rej);
    rd(REG_STATUS, 32'hf, {28'h0, rej, ovf, quad, wide});
  endtask
  task automatic one(input logic [31:0] v, input int nb);
    sfa_host_model_inst.start(1'b0);
    sfa_host_model_inst.shift(v, nb, quad ? 4 : 1);
    sfa_host_model_inst.stop();
  endtask
  task automatic run(input int k, input logic pol, input logic [31:0] a);
    int          al, dl, dm, n;
    logic [7:0]  op, b;
    logic [31:0] e;
    op = ops[k];
    al = op inside {8'hbb, 8'hbc} ? 2 : op inside {8'heb, 8'hec, 8'hea, 8'h38} ? 4 : 1;
    dl = op inside {8'hbb, 8'hbc, 8'h3b, 8'h3c} ? 2 : op inside {8'heb, 8'hec, 8'hea, 8'h6b, 8'h6c} ? 4 : 1;
    dm = op inside {8'h03, 8'h13} ? 0 : op inside {8'heb, 8'hec, 8'hea} ? 6 : 8;
    n = (wide || (k >= 7 && k <= 12)) ? 32 : 24;
    e = n == 32 ? {7'h0, a[24:0]} : op == 8'hea ? {8'h1, a[23:0]} : {7'h0, seg, a[23:0]};
    sfa_host_model_inst.start(pol);
    sfa_host_model_inst.shift({24'h0, op}, 8, quad ? 4 : 1);
    sfa_host_model_inst.shift(a, n, al);
    if (k < 13) begin
      sfa_host_model_inst.shift(32'h0, dm * al, al);
      for (int j = 0; j < 2; j++) begin
        sfa_host_model_inst.rx(b, dl);
        chk(b, mb(e + j));
      end
    end
    sfa_host_model_inst.stop();
    expq.push_back({k < 13 ? CMD_READ : (k < 15 ? CMD_PROGRAM : CMD_ERASE), op, e});
  endtask
  task automatic flush();
    for (int t = 0; t < 300 && gotq.size() < expq.size(); t++)
      @(posedge core_clk);
    // Count mismatch is recorded; the verdict still comes from close_out at the end
    if (gotq.size() != expq.size()) begin
      error_cnt++;
      $display("Error at %0t: command count off", $time);
      gotq.delete();
      expq.delete();
    end
    while (expq.size() > 0)
      chk(gotq.pop_front(), expq.pop_front());
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(REG_EXT_SEG, 32'hffffffff, 32'h0);
    st(1'b0, 1'b0);
    wr(REG_EXT_SEG, 32'hff);
    rd(REG_EXT_SEG, 32'hffffffff, 32'h1);
    wr(4'h8, 32'hff);
    rd(4'h8, 32'hffffffff, 32'h0);
    // Both segments, every address-taking opcode, both clock idle levels
    for (int s = 0; s < 2; s++) begin
      seg = s[0];
      wr(REG_EXT_SEG, {31'h0, seg});
      for (int k = 0; k < 18; k++)
        run(k, k[0], k == 0 ? 32'hffffff : $random(seed));
      flush();
      rd(REG_EXT_SEG, 32'hffffffff, {31'h0, seg});
    end
    one(8'hb7, 8);
    wide = 1'b1;
    st(1'b0, 1'b0);
    for (int k = 0; k < 18; k++)
      if (k != 6)
        run(k, 1'b0, $random(seed));
    flush();
    one(8'he9, 8);
    wide = 1'b0;
    run(0, 1'b1, $random(seed));
    flush();
    one(7'(8'hb7 >> 1), 7);
    one({8'h35, 1'b0}, 9);
    st(1'b0, 1'b1);
    wr(REG_STATUS, 32'h8);
    st(1'b0, 1'b0);
    one(8'h35, 8);
    quad = 1'b1;
    st(1'b0, 1'b0);
    run(4, 1'b1, $random(seed));
    one(8'hf5, 8);
    quad = 1'b0;
    st(1'b0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      one(i ? 8'hc7 : 8'h60, 8);
      expq.push_back({CMD_CHIP_ERASE, i ? 8'hc7 : 8'h60, 32'h0});
    end
    flush();
    // Two buffered, one pending, the fourth is lost
    stall <= 1'b1;
    for (int i = 0; i < 4; i++)
      run(15, 1'b0, $random(seed));
    void'(expq.pop_back());
    st(1'b1, 1'b0);
    stall <= 1'b0;
    flush();
    wr(REG_STATUS, 32'h4);
    st(1'b0, 1'b0);
    close_out();
  end
endmodule
